// ===== smo_regs.svh
`ifndef SMO_REGS_SVH
`define SMO_REGS_SVH

// Register byte offsets
`define SMO_CTRL_OFS        8'h00
`define SMO_CRANGE_OFS      8'h04
`define SMO_CHOLD_OFS       8'h08
`define SMO_ZSPD_OFS        8'h0C
`define SMO_MATCH_OFS       8'h10
`define SMO_ROT_OFS         8'h14
`define SMO_BSTOP_OFS       8'h18
`define SMO_BRUN_OFS        8'h1C
`define SMO_BREL_OFS        8'h20
`define SMO_A2OFS_OFS       8'h24
`define SMO_A2TC_OFS        8'h28
`define SMO_A2EXC_OFS       8'h2C
`define SMO_A3OFS_OFS       8'h30
`define SMO_A3TC_OFS        8'h34
`define SMO_A3EXC_OFS       8'h38
`define SMO_FLAGS_OFS       8'h3C
`define SMO_ISTAT_OFS       8'h40
`define SMO_IMASK_OFS       8'h44
`define SMO_A2FLT_OFS       8'h48
`define SMO_A3FLT_OFS       8'h4C

// Field positions of the live flag register and of the interrupt bits
`define SMO_BIT_COMP        0
`define SMO_BIT_ZERO        1
`define SMO_BIT_MATCH       2
`define SMO_BIT_ROT         3
`define SMO_BIT_BRAKE       4
`define SMO_BIT_A2EXC       5
`define SMO_BIT_A3EXC       6
`define SMO_BIT_POWER       7
`define SMO_NUM_IRQ         7

// Reset values of the parameter registers
`define SMO_CRANGE_RST      19'h0000A
`define SMO_CHOLD_RST       15'h0000
`define SMO_ZSPD_RST        15'h0032
`define SMO_MATCH_RST       15'h0032
`define SMO_ROT_RST         15'h03E8
`define SMO_BDLY_RST        14'h0000
`define SMO_BREL_RST        12'h01E
`define SMO_COND_RST        2'h0

// Timing: clock period, parameter step sizes, derived cycle counts
`define SMO_CLK_NS          40
`define SMO_MS_NS           1000000
`define SMO_TC_STEP_NS      10000
`define SMO_MS_CYC          (`SMO_MS_NS / `SMO_CLK_NS)
`define SMO_TC_CYC          (`SMO_TC_STEP_NS / `SMO_CLK_NS)

// Analog scaling: offset step in 0.01 mV, excess step in mV
`define SMO_OFS_STEP_CMV    586
`define SMO_CMV_PER_MV      100
`define SMO_EXC_STEP_MV     100

`endif

// ===== smo_pkg.sv
package smo_pkg;

	// Brake sequencer states
	typedef enum logic [1:0] {
		SMO_BRK_RUN,
		SMO_BRK_STOP_WAIT,
		SMO_BRK_RUN_WAIT,
		SMO_BRK_OFF
	} smo_brk_state_t;

	// Completion condition selections
	typedef enum logic [1:0] {
		SMO_COND_RANGE,
		SMO_COND_NO_CMD,
		SMO_COND_ZERO,
		SMO_COND_LATCH
	} smo_cond_t;

endpackage

// ===== smo_tick.sv
`timescale 1ns/1ps
// One-cycle enable pulse every DIV clock cycles
module smo_tick #(
	parameter int DIV = 250
) (
	input  wire logic clk_sys_in,
	input  wire logic sys_rst_in,
	output logic      tick_out
);
	logic [31:0] cnt;

	// Free-running divider
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			cnt      <= 32'h0;
			tick_out <= 1'b0;
		end else if (cnt == 32'(DIV - 1)) begin
			cnt      <= 32'h0;
			tick_out <= 1'b1;
		end else begin
			cnt      <= cnt + 32'h1;
			tick_out <= 1'b0;
		end
	end
endmodule

// ===== smo_status.sv
// What this block does
// - Holds a completion range in command units, reset value 10, up to 262,144.
// - Condition 0 asserts completion whenever the position error is inside the range.
// - Condition 1 also requires that no position command is active.
// - Condition 2 also requires the zero speed indication besides range and no command.
// - Condition 3 latches completion once reached until the next position command.
// - Completion is held on for a programmable time in 1 ms steps, 0 to 30,000.
// - Motor speed is compared with a zero speed threshold, reset value 50 r/min.
// - Speed match is asserted while speed command minus actual speed is within its range.
// - Rotation detection uses a threshold with reset value 1000 r/min.
// - At stop the brake engages first and power is kept for a 1 ms step delay.
// - While running, power drops and the brake engages after a 1 ms step delay.
// - While running, the brake also engages once speed falls below the release speed.
// - An analog input is flagged in excess when its offset-corrected level passes a 0.1 V step limit.
// - Analog inputs 2 and 3 are low-pass filtered with a 0.01 ms step time constant.
// - Analog inputs 2 and 3 get a signed offset in 5.86 mV steps, -342 to 342.
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "smo_regs.svh"
module smo_status
	import smo_pkg::*;
#(
	parameter int MS_CYCLES = `SMO_MS_CYC,
	parameter int TC_CYCLES = `SMO_TC_CYC
) (
	input  wire logic               clk_sys_in,
	input  wire logic               sys_rst_in,
	input  wire logic [7:0]         addr_in,
	input  wire logic [31:0]        wdata_in,
	input  wire logic               wr_in,
	input  wire logic               rd_in,
	output logic      [31:0]        rdata_out,
	input  wire logic signed [31:0] pos_err_in,
	input  wire logic               pos_cmd_in,
	input  wire logic signed [15:0] speed_in,
	input  wire logic signed [15:0] speed_cmd_in,
	input  wire logic               servo_on_in,
	input  wire logic signed [15:0] ain2_in,
	input  wire logic signed [15:0] ain3_in,
	output logic                    completion_flag_out,
	output logic                    zero_speed_flag_out,
	output logic                    speed_match_flag_out,
	output logic                    rotation_detect_flag_out,
	output logic                    brake_release_out,
	output logic                    motor_power_out,
	output logic                    ain2_excess_out,
	output logic                    ain3_excess_out,
	output logic                    irq_out
);
	// Parameter registers
	smo_cond_t          completion_condition_param;
	logic [18:0]        completion_range_param;
	logic [14:0]        completion_hold_param;
	logic [14:0]        zero_speed_threshold_param;
	logic [14:0]        speed_match_range_param;
	logic [14:0]        rotation_threshold_param;
	logic [13:0]        brake_stop_delay_param;
	logic [13:0]        brake_run_delay_param;
	logic [11:0]        brake_release_speed_param;
	logic signed [9:0]  ain_ofs [2];
	logic [12:0]        ain_tc  [2];
	logic [6:0]         ain_exc [2];
	logic [`SMO_NUM_IRQ-1:0] irq_stat;
	logic [`SMO_NUM_IRQ-1:0] irq_mask;

	// Internal state
	logic                    ms_tick;
	logic                    tc_tick;
	logic [14:0]             hold_cnt;
	logic                    comp_latch;
	logic                    comp_raw;
	logic                    in_range;
	logic [15:0]             abs_speed;
	logic [16:0]             abs_diff;
	smo_brk_state_t          brk_state;
	smo_brk_state_t          next_brk_state;
	logic [13:0]             brk_cnt;
	logic signed [16:0]      ain_corr [2];
	logic signed [24:0]      ain_acc  [2];
	logic [1:0]              next_exc;
	logic                    next_comp;
	logic                    next_rot;
	logic [`SMO_NUM_IRQ-1:0] irq_ev;
	logic                    wr_stat;

	function automatic logic [15:0] abs16(input logic signed [15:0] v);
		return v[15] ? 16'(-v) : 16'(v);
	endfunction

	function automatic logic [16:0] abs17(input logic signed [16:0] v);
		return v[16] ? 17'(-v) : 17'(v);
	endfunction

	// Offset code to millivolts
	function automatic logic signed [16:0] ofs_mv(input logic signed [9:0] code);
		logic signed [21:0] p;
		p = 22'(code);
		p = p * 22'(`SMO_OFS_STEP_CMV);
		p = p / 22'(`SMO_CMV_PER_MV);
		return p[16:0];
	endfunction

	// Filter shift: bits needed to hold the time constant
	function automatic logic [3:0] tc_shift(input logic [12:0] tc);
		logic [3:0] s;
		s = 4'h0;
		for (int i = 0; i < 13; i++) begin
			if (tc[i]) begin
				s = 4'(i + 1);
			end
		end
		return s;
	endfunction

	// Time base enables
	smo_tick #(.DIV(MS_CYCLES)) u_ms_tick (
		.clk_sys_in (clk_sys_in),
		.sys_rst_in (sys_rst_in),
		.tick_out   (ms_tick)
	);

	smo_tick #(.DIV(TC_CYCLES)) u_tc_tick (
		.clk_sys_in (clk_sys_in),
		.sys_rst_in (sys_rst_in),
		.tick_out   (tc_tick)
	);

	// Parameter writes
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			completion_condition_param <= smo_cond_t'(`SMO_COND_RST);
			completion_range_param     <= `SMO_CRANGE_RST;
			completion_hold_param      <= `SMO_CHOLD_RST;
			zero_speed_threshold_param <= `SMO_ZSPD_RST;
			speed_match_range_param    <= `SMO_MATCH_RST;
			rotation_threshold_param   <= `SMO_ROT_RST;
			brake_stop_delay_param     <= `SMO_BDLY_RST;
			brake_run_delay_param      <= `SMO_BDLY_RST;
			brake_release_speed_param  <= `SMO_BREL_RST;
			irq_mask                   <= '0;
			for (int i = 0; i < 2; i++) begin
				ain_ofs[i] <= '0;
				ain_tc[i]  <= '0;
				ain_exc[i] <= '0;
			end
		end else if (wr_in) begin
			unique case (addr_in)
				`SMO_CTRL_OFS:   completion_condition_param <= smo_cond_t'(wdata_in[1:0]);
				`SMO_CRANGE_OFS: completion_range_param     <= wdata_in[18:0];
				`SMO_CHOLD_OFS:  completion_hold_param      <= wdata_in[14:0];
				`SMO_ZSPD_OFS:   zero_speed_threshold_param <= wdata_in[14:0];
				`SMO_MATCH_OFS:  speed_match_range_param    <= wdata_in[14:0];
				`SMO_ROT_OFS:    rotation_threshold_param   <= wdata_in[14:0];
				`SMO_BSTOP_OFS:  brake_stop_delay_param     <= wdata_in[13:0];
				`SMO_BRUN_OFS:   brake_run_delay_param      <= wdata_in[13:0];
				`SMO_BREL_OFS:   brake_release_speed_param  <= wdata_in[11:0];
				`SMO_A2OFS_OFS:  ain_ofs[0] <= wdata_in[9:0];
				`SMO_A2TC_OFS:   ain_tc[0]  <= wdata_in[12:0];
				`SMO_A2EXC_OFS:  ain_exc[0] <= wdata_in[6:0];
				`SMO_A3OFS_OFS:  ain_ofs[1] <= wdata_in[9:0];
				`SMO_A3TC_OFS:   ain_tc[1]  <= wdata_in[12:0];
				`SMO_A3EXC_OFS:  ain_exc[1] <= wdata_in[6:0];
				`SMO_IMASK_OFS:  irq_mask   <= wdata_in[`SMO_NUM_IRQ-1:0];
				default: ;
			endcase
		end
	end

	// Speed comparisons
	always_comb begin
		abs_speed = abs16(speed_in);
		abs_diff  = abs17(17'(speed_cmd_in) - 17'(speed_in));
		in_range  = abs17(pos_err_in[31] ? 17'h1FFFF : 17'h0) == 17'h0
			? ({13'h0, pos_err_in[18:0]} <= {13'h0, completion_range_param})
				&& (pos_err_in[31:19] == 13'h0)
			: (32'(-pos_err_in) <= {13'h0, completion_range_param});
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			zero_speed_flag_out      <= 1'b0;
			speed_match_flag_out     <= 1'b0;
			rotation_detect_flag_out <= 1'b0;
		end else begin
			zero_speed_flag_out      <= abs_speed < {1'b0, zero_speed_threshold_param};
			speed_match_flag_out     <= abs_diff <= {2'b0, speed_match_range_param};
			rotation_detect_flag_out <= next_rot;
		end
	end
	assign next_rot = abs_speed >= {1'b0, rotation_threshold_param};

	// Completion condition selection
	always_comb begin
		unique case (completion_condition_param)
			SMO_COND_RANGE:  comp_raw = in_range;
			SMO_COND_NO_CMD: comp_raw = in_range && !pos_cmd_in;
			SMO_COND_ZERO:   comp_raw = in_range && !pos_cmd_in && zero_speed_flag_out;
			SMO_COND_LATCH:  comp_raw = (in_range || comp_latch) && !pos_cmd_in;
		endcase
		next_comp = comp_raw || (hold_cnt != 15'h0);
	end

	// Latch for condition 3, released by the next command
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			comp_latch <= 1'b0;
		end else begin
			comp_latch <= completion_condition_param == SMO_COND_LATCH && comp_raw;
		end
	end

	// Hold timer reloads while the condition stands, counts down after
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			hold_cnt            <= 15'h0;
			completion_flag_out <= 1'b0;
		end else begin
			completion_flag_out <= next_comp;
			if (comp_raw) begin
				hold_cnt <= completion_hold_param;
			end else if (ms_tick && hold_cnt != 15'h0) begin
				hold_cnt <= hold_cnt - 15'h1;
			end
		end
	end

	// Brake sequencer transitions
	always_comb begin
		next_brk_state = brk_state;
		unique case (brk_state)
			SMO_BRK_RUN: begin
				if (!servo_on_in) begin
					next_brk_state = zero_speed_flag_out ? SMO_BRK_STOP_WAIT
						: SMO_BRK_RUN_WAIT;
				end
			end
			SMO_BRK_STOP_WAIT: begin
				if (servo_on_in) begin
					next_brk_state = SMO_BRK_RUN;
				end else if (brk_cnt == 14'h0) begin
					next_brk_state = SMO_BRK_OFF;
				end
			end
			SMO_BRK_RUN_WAIT: begin
				if (brk_cnt == 14'h0 || abs_speed < {4'h0, brake_release_speed_param}) begin
					next_brk_state = SMO_BRK_OFF;
				end
			end
			SMO_BRK_OFF: begin
				if (servo_on_in) begin
					next_brk_state = SMO_BRK_RUN;
				end
			end
		endcase
	end

	// Brake state, delay counter and drive outputs
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			brk_state         <= SMO_BRK_OFF;
			brk_cnt           <= 14'h0;
			brake_release_out <= 1'b0;
			motor_power_out   <= 1'b0;
		end else begin
			brk_state         <= next_brk_state;
			brake_release_out <= next_brk_state == SMO_BRK_RUN
				|| next_brk_state == SMO_BRK_RUN_WAIT;
			motor_power_out   <= next_brk_state == SMO_BRK_RUN
				|| next_brk_state == SMO_BRK_STOP_WAIT;
			if (brk_state == SMO_BRK_RUN && next_brk_state == SMO_BRK_STOP_WAIT) begin
				brk_cnt <= brake_stop_delay_param;
			end else if (brk_state == SMO_BRK_RUN && next_brk_state == SMO_BRK_RUN_WAIT) begin
				brk_cnt <= brake_run_delay_param;
			end else if (ms_tick && brk_cnt != 14'h0) begin
				brk_cnt <= brk_cnt - 14'h1;
			end
		end
	end

	// Analog offset, excess check and first-order filter
	always_comb begin
		ain_corr[0] = 17'(ain2_in) + ofs_mv(ain_ofs[0]);
		ain_corr[1] = 17'(ain3_in) + ofs_mv(ain_ofs[1]);
		for (int i = 0; i < 2; i++) begin
			next_exc[i] = ain_exc[i] != 7'h0 && abs17(ain_corr[i])
				> 17'(ain_exc[i] * 14'(`SMO_EXC_STEP_MV));
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			ain2_excess_out <= 1'b0;
			ain3_excess_out <= 1'b0;
			for (int i = 0; i < 2; i++) begin
				ain_acc[i] <= '0;
			end
		end else begin
			ain2_excess_out <= next_exc[0];
			ain3_excess_out <= next_exc[1];
			for (int i = 0; i < 2; i++) begin
				if (ain_tc[i] == 13'h0) begin
					ain_acc[i] <= {ain_corr[i], 8'h00};
				end else if (tc_tick) begin
					// Signed step so a falling input pulls the accumulator down
					ain_acc[i] <= ain_acc[i]
						+ (($signed({ain_corr[i], 8'h00}) - ain_acc[i])
						>>> tc_shift(ain_tc[i]));
				end
			end
		end
	end

	// Interrupt events: rising edges of selected flags, falling edge of brake release, set wins over clear
	assign irq_ev = {next_exc[1] && !ain3_excess_out, next_exc[0] && !ain2_excess_out,
		brake_release_out && next_brk_state != SMO_BRK_RUN
			&& next_brk_state != SMO_BRK_RUN_WAIT,
		next_rot && !rotation_detect_flag_out, 2'b00, next_comp && !completion_flag_out};
	assign wr_stat = wr_in && addr_in == `SMO_ISTAT_OFS;

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			irq_stat <= '0;
			irq_out  <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~(wr_stat ? wdata_in[`SMO_NUM_IRQ-1:0] : '0)) | irq_ev;
			irq_out  <= |(((irq_stat & ~(wr_stat ? wdata_in[`SMO_NUM_IRQ-1:0] : '0))
				| irq_ev) & irq_mask);
		end
	end

	// Read port, data valid the cycle after the strobe
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			rdata_out <= 32'h0;
		end else if (rd_in) begin
			unique case (addr_in)
				`SMO_CTRL_OFS:   rdata_out <= 32'(completion_condition_param);
				`SMO_CRANGE_OFS: rdata_out <= 32'(completion_range_param);
				`SMO_CHOLD_OFS:  rdata_out <= 32'(completion_hold_param);
				`SMO_ZSPD_OFS:   rdata_out <= 32'(zero_speed_threshold_param);
				`SMO_MATCH_OFS:  rdata_out <= 32'(speed_match_range_param);
				`SMO_ROT_OFS:    rdata_out <= 32'(rotation_threshold_param);
				`SMO_BSTOP_OFS:  rdata_out <= 32'(brake_stop_delay_param);
				`SMO_BRUN_OFS:   rdata_out <= 32'(brake_run_delay_param);
				`SMO_BREL_OFS:   rdata_out <= 32'(brake_release_speed_param);
				`SMO_A2OFS_OFS:  rdata_out <= 32'(ain_ofs[0]);
				`SMO_A2TC_OFS:   rdata_out <= 32'(ain_tc[0]);
				`SMO_A2EXC_OFS:  rdata_out <= 32'(ain_exc[0]);
				`SMO_A3OFS_OFS:  rdata_out <= 32'(ain_ofs[1]);
				`SMO_A3TC_OFS:   rdata_out <= 32'(ain_tc[1]);
				`SMO_A3EXC_OFS:  rdata_out <= 32'(ain_exc[1]);
				`SMO_FLAGS_OFS:  rdata_out <= 32'({motor_power_out, ain3_excess_out,
					ain2_excess_out, brake_release_out, rotation_detect_flag_out,
					speed_match_flag_out, zero_speed_flag_out, completion_flag_out});
				`SMO_ISTAT_OFS:  rdata_out <= 32'(irq_stat);
				`SMO_IMASK_OFS:  rdata_out <= 32'(irq_mask);
				`SMO_A2FLT_OFS:  rdata_out <= 32'(ain_acc[0][24:8]);
				`SMO_A3FLT_OFS:  rdata_out <= 32'(ain_acc[1][24:8]);
				default:         rdata_out <= 32'h0;
			endcase
		end else begin
			rdata_out <= 32'h0;
		end
	end

	// Checks
	sequence s_stop_req;
		brk_state == SMO_BRK_RUN && !servo_on_in && zero_speed_flag_out;
	endsequence
	sequence s_run_req;
		brk_state == SMO_BRK_RUN && !servo_on_in && !zero_speed_flag_out;
	endsequence

	property p_zero;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		1'b1 |=> zero_speed_flag_out == ($past(abs_speed) < {1'b0, $past(zero_speed_threshold_param)});
	endproperty
	a_zero: assert property (p_zero) else $error("zero speed flag wrong");

	property p_rot;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(abs_speed >= {1'b0, rotation_threshold_param}) |=> rotation_detect_flag_out;
	endproperty
	a_rot: assert property (p_rot) else $error("rotation flag missing");

	property p_match;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(abs_diff > {2'b0, speed_match_range_param}) |=> !speed_match_flag_out;
	endproperty
	a_match: assert property (p_match) else $error("speed match flag wrong");

	property p_cmp_range;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(completion_condition_param == SMO_COND_RANGE && in_range) |=> completion_flag_out;
	endproperty
	a_cmp_range: assert property (p_cmp_range) else $error("completion missing");

	property p_cmp_cmd;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(completion_condition_param == SMO_COND_NO_CMD && pos_cmd_in && hold_cnt == 15'h0)
			|=> !completion_flag_out;
	endproperty
	a_cmp_cmd: assert property (p_cmp_cmd) else $error("completion during command");

	property p_cmp_zero;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(completion_condition_param == SMO_COND_ZERO && !zero_speed_flag_out
			&& hold_cnt == 15'h0) |=> !completion_flag_out;
	endproperty
	a_cmp_zero: assert property (p_cmp_zero) else $error("completion without zero speed");

	property p_cmp_latch;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(completion_condition_param == SMO_COND_LATCH && comp_latch && !pos_cmd_in)
			|=> completion_flag_out;
	endproperty
	a_cmp_latch: assert property (p_cmp_latch) else $error("latched completion lost");

	property p_hold;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(!comp_raw && hold_cnt != 15'h0) |=> completion_flag_out;
	endproperty
	a_hold: assert property (p_hold) else $error("completion hold cut short");

	property p_brk_stop;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		s_stop_req |=> !brake_release_out && motor_power_out;
	endproperty
	a_brk_stop: assert property (p_brk_stop) else $error("stop brake order wrong");

	property p_brk_run;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		s_run_req |=> brake_release_out && !motor_power_out;
	endproperty
	a_brk_run: assert property (p_brk_run) else $error("run brake order wrong");

	property p_brk_rel;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(brk_state == SMO_BRK_RUN_WAIT && abs_speed < {4'h0, brake_release_speed_param})
			|=> !brake_release_out;
	endproperty
	a_brk_rel: assert property (p_brk_rel) else $error("brake late below release speed");

	property p_exc;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(ain_exc[0] != 7'h0 && abs17(ain_corr[0]) > 17'(ain_exc[0] * 14'd100))
			|=> ain2_excess_out;
	endproperty
	a_exc: assert property (p_exc) else $error("analog excess missed");
endmodule

// ===== smo_host.sv
`timescale 1ns/1ps
// Host controller: registers its run and move requests onto the drive inputs
module smo_host (
	input  wire logic clk_sys_in,
	input  wire logic sys_rst_in,
	input  wire logic run_req_in,
	input  wire logic move_req_in,
	output logic      servo_on_out,
	output logic      pos_cmd_out
);
	// Requests leave one cycle after being asked for, cleared in reset
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			servo_on_out <= 1'b0;
			pos_cmd_out  <= 1'b0;
		end else begin
			servo_on_out <= run_req_in;
			pos_cmd_out  <= move_req_in;
		end
	end
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
`include "smo_regs.svh"
module testbench;
	logic               clk_sys_in = 1'b0;
	logic               sys_rst_in = 1'b1;
	logic        [7:0]  addr       = 8'h00;
	logic        [31:0] wdata      = 32'h0;
	logic               wr_s       = 1'b0;
	logic               rd_s       = 1'b0;
	logic               run_req    = 1'b0;
	logic               move_req   = 1'b0;
	logic signed [31:0] pos_err    = 32'sh0;
	logic signed [15:0] speed      = 16'sh0;
	logic signed [15:0] speed_cmd  = 16'sh0;
	logic signed [15:0] ain2       = 16'sh0;
	logic signed [15:0] ain3       = 16'sh0;
	logic               ex3;
	logic        [31:0] rdata, rv;
	logic               servo_on, pos_cmd, comp, zero, match, rot, brake, power, ex2, irq;
	int                 err_total  = 0;
	int                 compares   = 0;
	int                 cyc        = 0;
	int                 sp, sc;
	logic        [7:0]  rst_a[7]   = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h80};
	logic        [31:0] rst_v[7]   = '{32'hA, 32'h0, 32'h32, 32'h32, 32'h3E8, 32'h1E, 32'h0};

	smo_status #(.MS_CYCLES(25), .TC_CYCLES(5)) smo_status_i (
		.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata), .pos_err_in(pos_err),
		.pos_cmd_in(pos_cmd), .speed_in(speed), .speed_cmd_in(speed_cmd),
		.servo_on_in(servo_on), .ain2_in(ain2), .ain3_in(ain3),
		.completion_flag_out(comp), .zero_speed_flag_out(zero),
		.speed_match_flag_out(match), .rotation_detect_flag_out(rot),
		.brake_release_out(brake), .motor_power_out(power), .ain2_excess_out(ex2),
		.ain3_excess_out(ex3), .irq_out(irq));

	smo_host smo_host_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
		.run_req_in(run_req), .move_req_in(move_req), .servo_on_out(servo_on),
		.pos_cmd_out(pos_cmd));

	// Clock and hang guard
	always #20 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			err_total++;
			summarize();
		end
	end

	function automatic int ab(input int v);
		return (v < 0) ? -v : v;
	endfunction

	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		addr  <= a;
		wdata <= d;
		wr_s  <= 1'b1;
		@(posedge clk_sys_in);
		wr_s  <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_sys_in);
		rd_s <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Sets error, move request and speed, then lets the host and flags settle
	task automatic setp(input int e, input logic mv, input int s);
		@(posedge clk_sys_in);
		pos_err  <= 32'(e);
		move_req <= mv;
		speed    <= 16'(s);
		settle(3);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		if (err_total == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		void'($urandom(32'h2339));
		repeat (4) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		// Reset values, then an unmapped address
		for (int i = 0; i < 7; i++) begin
			rd(rst_a[i], rv);
			chk(rv, rst_v[i]);
		end
		// Speed flags at boundaries, then random speeds
		wr(`SMO_ZSPD_OFS, 32'd40);
		wr(`SMO_ROT_OFS, 32'd500);
		for (int i = 0; i < 30; i++) begin
			sp = (i < 4) ? (i * 460 - 500) : int'($urandom_range(3000)) - 1500;
			sc = sp + ((i < 4) ? 50 + i % 2 : int'($urandom_range(120)) - 60);
			@(posedge clk_sys_in);
			speed     <= 16'(sp);
			speed_cmd <= 16'(sc);
			settle(2);
			chk(zero, ab(sp) < 40);
			chk(rot, ab(sp) >= 500);
			chk(match, ab(sc - sp) <= 50);
		end
		// Completion conditions 0 to 2 over error edge, command and speed
		wr(`SMO_CRANGE_OFS, 32'd20);
		for (int c = 0; c < 3; c++) begin
			wr(`SMO_CTRL_OFS, 32'(c));
			for (int k = 0; k < 16; k++) begin
				setp((20 + k % 2) * ((k & 8) ? -1 : 1), k[1], (k & 4) ? 100 : 0);
				chk(comp, !k[0] && (c == 0 || !k[1]) && (c < 2 || !k[2]));
			end
		end
		// Latched completion released only by the next command
		wr(`SMO_CTRL_OFS, 32'd3);
		setp(0, 1'b0, 0);
		setp(500, 1'b0, 0);
		chk(comp, 1'b1);
		setp(500, 1'b1, 0);
		chk(comp, 1'b0);
		// Two ms hold after the condition drops
		wr(`SMO_CTRL_OFS, 32'd0);
		wr(`SMO_CHOLD_OFS, 32'd2);
		setp(0, 1'b0, 0);
		setp(500, 1'b0, 0);
		settle(15);
		chk(comp, 1'b1);
		settle(40);
		chk(comp, 1'b0);
		// Brake at stop: power held for the stop delay
		chk({brake, power}, 2'b00);
		wr(`SMO_BSTOP_OFS, 32'd2);
		wr(`SMO_BRUN_OFS, 32'd4);
		run_req <= 1'b1;
		settle(3);
		chk({brake, power}, 2'b11);
		@(posedge clk_sys_in);
		run_req <= 1'b0;
		settle(3);
		chk({brake, power}, 2'b01);
		settle(60);
		chk({brake, power}, 2'b00);
		// Brake while running: held off until delay or low speed
		@(posedge clk_sys_in);
		run_req <= 1'b1;
		setp(0, 1'b0, 500);
		@(posedge clk_sys_in);
		run_req <= 1'b0;
		settle(60);
		chk({brake, power}, 2'b10);
		setp(0, 1'b0, 20);
		chk({brake, power}, 2'b00);
		// Analog offset, excess limit, filter bypass and interrupt
		wr(`SMO_A2OFS_OFS, 32'd10);
		wr(`SMO_A2EXC_OFS, 32'd1);
		wr(`SMO_IMASK_OFS, 32'h20);
		ain2 <= 16'sd42;
		settle(3);
		chk(ex2, 1'b0);
		chk(irq, 1'b0);
		@(posedge clk_sys_in);
		ain2 <= 16'sd43;
		settle(3);
		chk(ex2, 1'b1);
		chk(irq, 1'b1);
		rd(`SMO_A2FLT_OFS, rv);
		chk(rv, 32'd101);
		@(posedge clk_sys_in);
		ain2 <= 16'sd0;
		wr(`SMO_ISTAT_OFS, 32'h20);
		settle(3);
		chk(irq, 1'b0);
		// Input 3: negative offset, excess and a filtered falling step
		wr(`SMO_A3OFS_OFS, 32'h3F6);
		wr(`SMO_A3EXC_OFS, 32'd1);
		wr(`SMO_A3TC_OFS, 32'd1);
		ain3 <= -16'sd200;
		rd(`SMO_A3FLT_OFS, rv);
		chk(rv == 32'h1FEFE, 1'b0);
		settle(200);
		chk(ex3, 1'b1);
		rd(`SMO_A3FLT_OFS, rv);
		chk(rv, 32'h1FEFE);
		summarize();
	end
endmodule
